// ### ir_timer_pkg.sv
// Package: register map, field positions, reset values and modes of the IR carrier/envelope timers
`default_nettype none
package ir_timer_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] CARRIER_TIMER_CONTROL = 8'h21;
    localparam logic [7:0] ENVELOPE_TIMER_CONTROL = 8'h22;
    localparam logic [7:0] CARRIER_PERIOD_PRELOAD = 8'h23;
    localparam logic [7:0] CARRIER_HIGH_PULSE_PRELOAD = 8'h24;
    localparam logic [7:0] ENVELOPE_COUNT_LOW = 8'h25;
    localparam logic [7:0] ENVELOPE_COUNT_HIGH = 8'h26;
    localparam logic [7:0] IR_OUTPUT_CONTROL = 8'h27;
    localparam int RUN_BIT = 7;
    localparam int PIN_CLK_BIT = 6;
    localparam int CLK_SEL_HI = 5;
    localparam int CLK_SEL_LO = 4;
    localparam int ALT_MODE_BIT = 0;
    localparam int MARK_SPACE_BIT = 7;
    localparam int IR_DISABLE_BIT = 0;
    localparam logic [7:0] CARRIER_CTRL_MASK = 8'hB3;
    localparam logic [7:0] ENVELOPE_CTRL_MASK = 8'hF1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [11:0] ENV_RESET = 12'h000;
    // Prescaler terminal counts (divide-by minus one)
    localparam logic [3:0] DIV1_TC = 4'h0;
    localparam logic [3:0] DIV2_TC = 4'h1;
    localparam logic [3:0] DIV4_TC = 4'h3;
    localparam logic [3:0] DIV16_TC = 4'hF;
    localparam logic [5:0] ENV_DIV1_TC = 6'h00;
    localparam logic [5:0] ENV_DIV4_TC = 6'h03;
    localparam logic [5:0] ENV_DIV64_TC = 6'h3F;
    typedef enum logic [1:0] {
        MODE_WITH_CARRIER = 2'b00,
        MODE_NO_CARRIER = 2'b01,
        MODE_RSVD2 = 2'b10,
        MODE_RSVD3 = 2'b11
    } carrier_mode_t;
    typedef enum logic [2:0] {
        PWM_IDLE = 3'b001,
        PWM_LOW = 3'b010,
        PWM_HIGH = 3'b100
    } pwm_state_t;
endpackage
`default_nettype wire

// ### tick_if.sv
// Interface: tick from a prescaler toward a counter, with its terminal count
`default_nettype none
interface tick_if #(parameter int W = 4);
    logic run;
    logic [W-1:0] term;
    logic tick;
    modport src (input run, input term, output tick);
    modport dst (output run, output term, input tick);
endinterface
`default_nettype wire

// ### prescaler.sv
// Module: free prescaler producing one-cycle ticks every term+1 clocks while run is high
`default_nettype none
module prescaler #(parameter int W = 4) (
    input wire logic sys_clk, // System clock
    input wire logic reset_n, // Async reset, active low
    tick_if.src tk // Tick port
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    wire wrap = (cnt_q >= tk.term);
    // Restart from zero whenever stopped so the first tick is a full division
    assign cnt_d = (!tk.run || wrap) ? '0 : W'(cnt_q + 1'b1);
    assign tk.tick = tk.run && wrap;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ### envelope_counter.sv
// Module: 12-bit down counter with reload on overflow, used as the envelope timer
`default_nettype none
module envelope_counter #(parameter int W = 12) (
    input wire logic sys_clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic run, // Count enable
    input wire logic step, // One count event
    input wire logic [W-1:0] preload, // Reload value
    output logic [W-1:0] count, // Live count
    output logic overflow // One-cycle pulse on wrap past zero
);
    logic [W-1:0] count_d;
    // A step at zero is the underflow: reload instead of wrapping to all ones
    assign overflow = run && step && (count == '0);
    assign count_d = !run ? count : overflow ? preload : step ? W'(count - 1'b1) : count;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else begin
            count <= count_d;
        end
    end
endmodule
`default_nettype wire

// ### ir_carrier_envelope_timers.sv
// Top: IR carrier timer, envelope timer, register port and transmit pin logic
//
// Functional notes
// - Carrier timer counts only while control bit 7 is set.
// - Carrier clock select bits 5:4 give Fosc, /2, /4, /16.
// - Mode 00 is PWM with carrier; mode 01 drives PWM output high.
// - Count register write stores preload; read returns live counter.
// - Period register write stores period preload; read returns live counter.
// - High-pulse register holds duty preload and reads it back.
// - Envelope is 12-bit down counter on Fosc, /4, /64 or carrier.
// - Envelope overflow reloads from preload registers and sets overflow flag.
// - Envelope timer counts only while its control bit 7 is set.
// - Envelope bit 6 selects the port pin as envelope clock.
// - Envelope bit 0 enables envelope mode 2.
// - Low register write sets preload 7:0; read returns live count low.
// - High register bits 3:0 set preload top; read returns live count top.
// - High register bit 7 selects mark (1) or space (0) in mode 2.
// - Carrier output starts low, goes high at duty match, low on overflow.
// - With a divided envelope clock, carrier enable bit gates the pin directly.
// - Without carrier, the pin shows only the steady envelope level.
// - IR output disable bit suppresses the pin output entirely.
//
// Design decision made here: the strobed register port.
`default_nettype none
module ir_carrier_envelope_timers (
    input wire logic sys_clk, // 200 MHz system clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [ir_timer_pkg::ADDR_W-1:0] reg_addr, // Register address
    input wire logic [ir_timer_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [ir_timer_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic envelope_pin_clock, // Port pin used as envelope clock
    output logic ir_transmit_pin, // IR transmitter drive
    output logic envelope_overflow_flag, // Sticky overflow flag
    output logic envelope_overflow_pulse // One-cycle overflow event
);
    import ir_timer_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    // Writable control bits only
    logic [7:0] carrier_ctrl_q;
    logic [7:0] envelope_ctrl_q;

    // Preloads for start and reload
    logic [7:0] carrier_period_value;
    logic [7:0] carrier_high_value;
    logic [7:0] envelope_preload_low;
    logic [3:0] envelope_preload_high;
    logic envelope_mark_space;
    logic ir_output_disable;

    // Status and read-back
    logic flag_q;
    logic [7:0] rdata_q;

    // Field decode
    wire carrier_run = carrier_ctrl_q[RUN_BIT];
    wire [1:0] carrier_clk_sel = carrier_ctrl_q[CLK_SEL_HI:CLK_SEL_LO];
    wire [1:0] carrier_mode_sel = carrier_ctrl_q[1:0];

    wire envelope_run = envelope_ctrl_q[RUN_BIT];
    wire envelope_pin_clock_sel = envelope_ctrl_q[PIN_CLK_BIT];
    wire [1:0] envelope_clk_sel = envelope_ctrl_q[CLK_SEL_HI:CLK_SEL_LO];
    wire envelope_alt_mode_en = envelope_ctrl_q[ALT_MODE_BIT];

    // Address decode
    wire wr_cctl = reg_wr && (reg_addr == CARRIER_TIMER_CONTROL);
    wire wr_ectl = reg_wr && (reg_addr == ENVELOPE_TIMER_CONTROL);
    wire wr_per = reg_wr && (reg_addr == CARRIER_PERIOD_PRELOAD);
    wire wr_high = reg_wr && (reg_addr == CARRIER_HIGH_PULSE_PRELOAD);
    wire wr_elo = reg_wr && (reg_addr == ENVELOPE_COUNT_LOW);
    wire wr_ehi = reg_wr && (reg_addr == ENVELOPE_COUNT_HIGH);
    wire wr_irc = reg_wr && (reg_addr == IR_OUTPUT_CONTROL);

    // Software writes; masks keep reserved bits at zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            carrier_ctrl_q <= REG_RESET;
            envelope_ctrl_q <= REG_RESET;
            carrier_period_value <= REG_RESET;
            carrier_high_value <= REG_RESET;
            envelope_preload_low <= REG_RESET;
            envelope_preload_high <= 4'h0;
            envelope_mark_space <= 1'b0;
            ir_output_disable <= 1'b0;
        end else begin
            if (wr_cctl) carrier_ctrl_q <= reg_wdata & CARRIER_CTRL_MASK;
            if (wr_ectl) envelope_ctrl_q <= reg_wdata & ENVELOPE_CTRL_MASK;
            if (wr_per) carrier_period_value <= reg_wdata;
            if (wr_high) carrier_high_value <= reg_wdata;
            if (wr_elo) envelope_preload_low <= reg_wdata;
            if (wr_ehi) envelope_preload_high <= reg_wdata[3:0];
            if (wr_ehi) envelope_mark_space <= reg_wdata[MARK_SPACE_BIT];
            if (wr_irc) ir_output_disable <= reg_wdata[IR_DISABLE_BIT];
        end
    end

    // ****************************************
    // Carrier timer
    // ****************************************
    // Four bits reach divide-by-16
    tick_if #(.W(4)) ctick ();
    assign ctick.run = carrier_run;
    // Clock division select
    assign ctick.term = (carrier_clk_sel == 2'b00) ? DIV1_TC :
                        (carrier_clk_sel == 2'b01) ? DIV2_TC :
                        (carrier_clk_sel == 2'b10) ? DIV4_TC : DIV16_TC;

    // Restarts whenever the timer stops
    prescaler #(.W(4)) u_carrier_div (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tk(ctick)
    );

    // Counter, compare copy, output
    logic [7:0] carrier_cnt_q;
    logic [7:0] carrier_cnt_d;
    logic [7:0] duty_cmp_q;
    logic [7:0] duty_cmp_d;
    pwm_state_t pwm_q;
    pwm_state_t pwm_d;
    logic carrier_q;
    logic carrier_d;
    // A tick that finds zero overflows
    wire carrier_ovf = ctick.tick && (carrier_cnt_q == 8'h00) && (pwm_q != PWM_IDLE);

    // Start loads preloads, then count down; overflow reloads period and duty
    always_comb begin
        pwm_d = pwm_q;
        carrier_cnt_d = carrier_cnt_q;
        duty_cmp_d = duty_cmp_q;
        case (pwm_q)
            PWM_IDLE: begin
                if (carrier_run) begin
                    pwm_d = PWM_LOW;
                    carrier_cnt_d = carrier_period_value;
                    duty_cmp_d = carrier_high_value;
                end
            end
            PWM_LOW, PWM_HIGH: begin
                // Stop idles; restart reloads
                if (!carrier_run) begin
                    pwm_d = PWM_IDLE;
                end else if (carrier_ovf) begin
                    pwm_d = PWM_LOW;
                    carrier_cnt_d = carrier_period_value;
                    duty_cmp_d = carrier_high_value;
                end else if (ctick.tick) begin
                    carrier_cnt_d = carrier_cnt_q - 8'h01;
                    if ((carrier_cnt_q - 8'h01) == duty_cmp_q) pwm_d = PWM_HIGH;
                end
            end
            default: begin
                pwm_d = PWM_IDLE;
            end
        endcase
    end
    assign carrier_d = (pwm_d == PWM_HIGH);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_q <= PWM_IDLE;
            carrier_cnt_q <= REG_RESET;
            duty_cmp_q <= REG_RESET;
            carrier_q <= 1'b0;
        end else begin
            pwm_q <= pwm_d;
            carrier_cnt_q <= carrier_cnt_d;
            duty_cmp_q <= duty_cmp_d;
            carrier_q <= carrier_d;
        end
    end

    // Rising edge of the carrier is the envelope step in carrier-clock mode
    logic carrier_prev_q;
    wire carrier_rise = carrier_q && !carrier_prev_q;
    // Pin input is already synchronous
    logic pin_prev_q;
    wire pin_rise = envelope_pin_clock && !pin_prev_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            carrier_prev_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            carrier_prev_q <= carrier_q;
            pin_prev_q <= envelope_pin_clock;
        end
    end

    // ****************************************
    // Envelope timer
    // ****************************************
    // Six bits reach divide-by-64
    tick_if #(.W(6)) etick ();
    assign etick.run = envelope_run;
    assign etick.term = (envelope_clk_sel == 2'b00) ? ENV_DIV1_TC :
                        (envelope_clk_sel == 2'b01) ? ENV_DIV4_TC : ENV_DIV64_TC;

    // Used by the first three sources
    prescaler #(.W(6)) u_envelope_div (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tk(etick)
    );

    // Carrier clock only with pin off
    wire carrier_as_envelope_clock = !envelope_pin_clock_sel && (envelope_clk_sel == 2'b11);
    // Pin wins over the bits 5:4 selection; the pin edge is a plain sampled input
    wire env_step = envelope_pin_clock_sel ? pin_rise :
                    carrier_as_envelope_clock ? carrier_rise : etick.tick;
    // Preload writes act at next reload
    wire [11:0] env_preload = {envelope_preload_high, envelope_preload_low};
    logic [11:0] env_count;
    logic env_ovf;
    envelope_counter #(.W(12)) u_envelope (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .run(envelope_run),
        .step(env_step),
        .preload(env_preload),
        .count(env_count),
        .overflow(env_ovf)
    );

    // Sticky flag: overflow sets, writing 1 to its bit clears; set wins
    wire flag_clr = wr_ectl && reg_wdata[1];
    // Set wins over a clear in one cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= env_ovf | (flag_q & ~flag_clr);
        end
    end
    assign envelope_overflow_flag = flag_q;
    assign envelope_overflow_pulse = env_ovf;
    // Pulse is combinational, flag is not

    // Original envelope mode toggles mark/space on each overflow while the carrier clocks the envelope
    logic env_level_q;
    // Stop restores mark for a lit restart
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            env_level_q <= 1'b0;
        end else if (!envelope_run || !carrier_as_envelope_clock) begin
            env_level_q <= 1'b1;
        end else if (env_ovf) begin
            env_level_q <= ~env_level_q;
        end
    end

    // ****************************************
    // Transmit pin
    // ****************************************
    // Mode 2 takes the software level
    wire env_mark = envelope_alt_mode_en ? envelope_mark_space : env_level_q;
    // Divided clocks: run bit gates pin
    wire gate = carrier_as_envelope_clock && envelope_run ? env_mark : carrier_run;
    wire with_carrier = (carrier_mode_sel == MODE_WITH_CARRIER);
    // Carrier mode passes the carrier; the other modes show only the level
    wire tx_d = ir_output_disable ? 1'b0 :
                with_carrier ? (gate && carrier_d) :
                gate;

    // Registered so the pin cannot glitch
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_transmit_pin <= 1'b0;
        end else begin
            ir_transmit_pin <= tx_d;
        end
    end

    // ****************************************
    // Read port: data one cycle after the read strobe
    // ****************************************
    // Unmapped addresses read zero
    wire [7:0] rd_mux = (reg_addr == CARRIER_TIMER_CONTROL) ? carrier_ctrl_q :
                        (reg_addr == ENVELOPE_TIMER_CONTROL) ? {envelope_ctrl_q[7:2], flag_q, envelope_ctrl_q[0]} :
                        (reg_addr == CARRIER_PERIOD_PRELOAD) ? carrier_cnt_q :
                        (reg_addr == CARRIER_HIGH_PULSE_PRELOAD) ? carrier_high_value :
                        (reg_addr == ENVELOPE_COUNT_LOW) ? env_count[7:0] :
                        (reg_addr == ENVELOPE_COUNT_HIGH) ? {envelope_mark_space, 3'b000, env_count[11:8]} :
                        (reg_addr == IR_OUTPUT_CONTROL) ? {7'h00, ir_output_disable} : 8'h00;
    // Data stand one cycle, then zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= REG_RESET;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// ### ir_timers_props.sv
// Checker: concurrent properties on the ports of the IR carrier and envelope timers
`default_nettype none
module ir_timers_props (
    input wire logic sys_clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [ir_timer_pkg::ADDR_W-1:0] reg_addr, // Register address
    input wire logic [ir_timer_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [ir_timer_pkg::DATA_W-1:0] reg_rdata, // Read data
    input wire logic envelope_pin_clock, // Port pin clock
    input wire logic ir_transmit_pin, // IR drive
    input wire logic envelope_overflow_flag, // Sticky flag
    input wire logic envelope_overflow_pulse // Overflow event
);
    timeunit 1ns;
    timeprecision 1ps;
    import ir_timer_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    logic [7:0] cctl_q;
    logic [7:0] ectl_q;
    logic [7:0] duty_q;
    logic mark_q;
    logic dis_q;
    // ************************************************************
    // Shadow of the writable fields, masked as the map allows
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cctl_q <= 8'h00;
            ectl_q <= 8'h00;
            duty_q <= 8'h00;
            mark_q <= 1'b0;
            dis_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == CARRIER_TIMER_CONTROL) cctl_q <= reg_wdata & CARRIER_CTRL_MASK;
            if (reg_addr == ENVELOPE_TIMER_CONTROL) ectl_q <= reg_wdata & ENVELOPE_CTRL_MASK;
            if (reg_addr == CARRIER_HIGH_PULSE_PRELOAD) duty_q <= reg_wdata;
            if (reg_addr == ENVELOPE_COUNT_HIGH) mark_q <= reg_wdata[MARK_SPACE_BIT];
            if (reg_addr == IR_OUTPUT_CONTROL) dis_q <= reg_wdata[IR_DISABLE_BIT];
        end
    end
    // Pin conditions; three samples cover the register stage and the pin stage
    wire logic direct_gate = ectl_q[5:4] != 2'b11;
    wire logic stopped = !cctl_q[RUN_BIT] && direct_gate;
    wire logic steady_high = cctl_q[RUN_BIT] && cctl_q[1:0] == 2'b01 && direct_gate && !dis_q;
    AST_CCTL_READ: assert property ($past(reg_rd) && $past(reg_addr) == CARRIER_TIMER_CONTROL
        |-> reg_rdata == $past(cctl_q)) else $error("carrier control read mismatch");
    AST_ECTL_READ: assert property ($past(reg_rd) && $past(reg_addr) == ENVELOPE_TIMER_CONTROL
        |-> (reg_rdata & 8'hFD) == $past(ectl_q)) else $error("envelope control read mismatch");
    AST_DUTY_READ: assert property ($past(reg_rd) && $past(reg_addr) == CARRIER_HIGH_PULSE_PRELOAD
        |-> reg_rdata == $past(duty_q)) else $error("duty read mismatch");
    AST_HIGH_RSVD: assert property ($past(reg_rd) && $past(reg_addr) == ENVELOPE_COUNT_HIGH
        |-> reg_rdata[7:4] == {$past(mark_q), 3'b000}) else $error("envelope high read mismatch");
    AST_UNMAPPED: assert property ($past(reg_rd) && ($past(reg_addr) < 8'h21 || $past(reg_addr) > 8'h27)
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_FLAG_SET: assert property (envelope_overflow_pulse |=> envelope_overflow_flag)
        else $error("overflow did not set flag");
    AST_ENV_HOLD: assert property (!ectl_q[RUN_BIT] && !$past(ectl_q[RUN_BIT]) && !$past(ectl_q[RUN_BIT], 2)
        |-> !envelope_overflow_pulse) else $error("envelope overflow while stopped");
    AST_DISABLED_LOW: assert property (dis_q && $past(dis_q) && $past(dis_q, 2) |-> !ir_transmit_pin)
        else $error("pin driven while output disabled");
    AST_STOPPED_LOW: assert property (stopped && $past(stopped) && $past(stopped, 2) |-> !ir_transmit_pin)
        else $error("pin driven while carrier stopped");
    AST_MODE1_HIGH: assert property (steady_high && $past(steady_high) && $past(steady_high, 2)
        |-> ir_transmit_pin) else $error("pin not high in mode without carrier");
    COV_OVERFLOW: cover property (envelope_overflow_pulse);
    COV_PIN_RISE: cover property ($rose(ir_transmit_pin));
    COV_COUNT_READ: cover property ($past(reg_rd) && $past(reg_addr) == CARRIER_PERIOD_PRELOAD);
endmodule
`default_nettype wire

// ### ir_led_driver.sv
// Model: IR LED driver stage, tallies lit cycles and turn-on events
`default_nettype none
module ir_led_driver (
    input wire logic sys_clk, // System clock
    input wire logic drive, // Transmit pin from the timers
    output var int lit_cycles, // Cycles with the LED on
    output var int turn_ons // Off-to-on transitions
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q = 1'b0;
    // ************************************************************
    // LED stage: the duty and edge count tell us period and width
    // ************************************************************
    initial begin
        lit_cycles = 0;
        turn_ons = 0;
        forever begin
            @(posedge sys_clk);
            if (drive === 1'b1) lit_cycles <= lit_cycles + 1;
            if (drive === 1'b1 && last_q === 1'b0) turn_ons <= turn_ons + 1;
            last_q <= drive;
        end
    end
endmodule
`default_nettype wire

// ### ir_carrier_envelope_timers_bench.sv
// Testbench: register-driven scenarios for the IR carrier and envelope timers
`default_nettype none
module ir_carrier_envelope_timers_bench import ir_timer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic envelope_pin_clock = 1'b0;
    logic pin_en = 1'b0;
    wire logic [DATA_W-1:0] reg_rdata;
    wire logic ir_transmit_pin;
    wire logic envelope_overflow_flag;
    wire logic envelope_overflow_pulse;
    int num_errors = 0;
    int checked = 0;
    int pulses = 0;
    int lit_cycles;
    int turn_ons;
    int cdiv[4] = '{1, 2, 4, 16};
    int ediv[3] = '{1, 4, 64};
    ir_carrier_envelope_timers u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .envelope_pin_clock(envelope_pin_clock), .ir_transmit_pin(ir_transmit_pin),
        .envelope_overflow_flag(envelope_overflow_flag), .envelope_overflow_pulse(envelope_overflow_pulse));
    ir_led_driver u_led (.sys_clk(sys_clk), .drive(ir_transmit_pin), .lit_cycles(lit_cycles), .turn_ons(turn_ons));
    // ************************************************************
    // Clock, pin clock source and overflow tally
    // ************************************************************
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (pin_en) envelope_pin_clock <= ~envelope_pin_clock;
        if (envelope_overflow_pulse === 1'b1) pulses <= pulses + 1;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk({24'h0000_00, reg_rdata}, {24'h0000_00, exp});
    endtask
    // Windows are whole carrier periods, so the tallies do not depend on phase
    task automatic win(input int n, input int lit, input int ons);
        int l0;
        int o0;
        #1;
        l0 = lit_cycles;
        o0 = turn_ons;
        repeat (n) @(posedge sys_clk);
        #1 chk(lit_cycles - l0, lit);
        chk(turn_ons - o0, ons);
    endtask
    task automatic pls(input int n, input int exp);
        int p0;
        #1;
        p0 = pulses;
        repeat (n) @(posedge sys_clk);
        #1 chk(pulses - p0, exp);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int k = 0; k < 9; k++) rdc(8'h20 + k[7:0], 8'h00);
        wr(CARRIER_TIMER_CONTROL, 8'h7F);
        rdc(CARRIER_TIMER_CONTROL, 8'h33);
        wr(ENVELOPE_TIMER_CONTROL, 8'h7D);
        rdc(ENVELOPE_TIMER_CONTROL, 8'h71);
        wr(ENVELOPE_TIMER_CONTROL, 8'h00);
        wr(CARRIER_HIGH_PULSE_PRELOAD, 8'hA5);
        rdc(CARRIER_HIGH_PULSE_PRELOAD, 8'hA5);
        wr(CARRIER_PERIOD_PRELOAD, 8'h5A);
        rdc(CARRIER_PERIOD_PRELOAD, 8'h00);
        wr(ENVELOPE_COUNT_LOW, 8'h04);
        rdc(ENVELOPE_COUNT_LOW, 8'h00);
        wr(ENVELOPE_COUNT_HIGH, 8'h70);
        rdc(ENVELOPE_COUNT_HIGH, 8'h00);
        $display("Registers test done");
        // Period 9 and duty 3 give ten ticks a period, four of them high
        wr(CARRIER_PERIOD_PRELOAD, 8'h09);
        wr(CARRIER_HIGH_PULSE_PRELOAD, 8'h03);
        for (int i = 0; i < 4; i++) begin
            wr(CARRIER_TIMER_CONTROL, {2'b10, i[1:0], 4'h0});
            repeat (20 * cdiv[i]) @(posedge sys_clk);
            win(100 * cdiv[i], 40 * cdiv[i], 10);
        end
        wr(CARRIER_TIMER_CONTROL, 8'h00);
        repeat (5) @(posedge sys_clk);
        win(50, 0, 0);
        wr(CARRIER_TIMER_CONTROL, 8'h81);
        repeat (5) @(posedge sys_clk);
        win(50, 50, 0);
        wr(IR_OUTPUT_CONTROL, 8'h01);
        repeat (5) @(posedge sys_clk);
        win(50, 0, 0);
        rdc(IR_OUTPUT_CONTROL, 8'h01);
        wr(IR_OUTPUT_CONTROL, 8'h00);
        wr(CARRIER_TIMER_CONTROL, 8'h80);
        $display("Carrier test done");
        // Preload 4 overflows every fifth step
        for (int j = 0; j < 3; j++) begin
            wr(ENVELOPE_TIMER_CONTROL, {2'b10, j[1:0], 4'h0});
            repeat (10 * ediv[j]) @(posedge sys_clk);
            pls(50 * ediv[j], 10);
        end
        rdc(ENVELOPE_TIMER_CONTROL, 8'hA2);
        chk(32'(envelope_overflow_flag), 32'h0000_0001);
        wr(ENVELOPE_TIMER_CONTROL, 8'hC0);
        pls(100, 0);
        pin_en = 1'b1;
        repeat (20) @(posedge sys_clk);
        pls(100, 10);
        wr(ENVELOPE_TIMER_CONTROL, 8'h00);
        wr(ENVELOPE_TIMER_CONTROL, 8'h02);
        rdc(ENVELOPE_TIMER_CONTROL, 8'h00);
        chk(32'(envelope_overflow_flag), 32'h0000_0000);
        pls(100, 0);
        $display("Envelope test done");
        // Mode 2 on the carrier: five carrier periods a segment
        wr(ENVELOPE_COUNT_HIGH, 8'h80);
        wr(ENVELOPE_TIMER_CONTROL, 8'hB1);
        repeat (100) @(posedge sys_clk);
        win(100, 40, 10);
        wr(ENVELOPE_COUNT_HIGH, 8'h00);
        repeat (120) @(posedge sys_clk);
        win(100, 0, 0);
        // Mode 2 off: the level toggles on each overflow, five carrier periods a segment
        wr(ENVELOPE_TIMER_CONTROL, 8'h00);
        wr(ENVELOPE_TIMER_CONTROL, 8'hB0);
        repeat (100) @(posedge sys_clk);
        win(200, 40, 12);
        $display("Mode 2 test done");
        end_of_test();
    end
    initial begin
        #200us;
        num_errors++;
        end_of_test();
    end
endmodule
bind ir_carrier_envelope_timers ir_timers_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .envelope_pin_clock(envelope_pin_clock), .ir_transmit_pin(ir_transmit_pin),
    .envelope_overflow_flag(envelope_overflow_flag), .envelope_overflow_pulse(envelope_overflow_pulse));
`default_nettype wire
